// ==== design/cbs_sequencer.v ====
// host bring-up sequencer for a dual-channel rf-sampling converter
`timescale 1ns/1ps
`default_nettype none
`include "cbs_defs.vh"
// Summary of operation
// RQ1 - the reference is driven before the reset pulse is issued.
// RQ2 - reset is one low-high-low pulse on the reset outputs.
// RQ3 - at least 1 ms passes from power good to the reset pulse.
// RQ4 - the reset pulse stays high for at least 1 us.
// RQ5 - at least 100 ns passes from reset fall to the first serial enable.
// RQ6 - the trim set is written first after every power-up.
// RQ7 - interleave sets follow, channel a then channel b.
// RQ8 - a 50 ms estimation wait follows the interleave sets.
// RQ9 - nonlinearity sets follow, channel a then channel b.
// RQ10 - the link and down-converter set is written last.
// RQ11 - two select bits map 00,01,10 to profiles one to three, 11 none.
// RQ12 - each select bit sits on a pin chosen by a 2-bit field.
// RQ13 - a pin with direction 0 is an input to the oscillator select.
// RQ14 - each step's writes finish before the next; power loss restarts.
module cbs_sequencer #(
  parameter PWR_CYC = `CBS_PWR_CYC,
  parameter EST_CYC = `CBS_EST_CYC
) (
  input  wire       sys_clk,
  input  wire       reset_n,
  input  wire       power_good,
  input  wire       start,
  output wire       ref_enable,
  output wire       conv_reset,
  output wire       set_req,
  output wire [2:0] set_id,
  input  wire       set_done,
  output wire       serial_enable_ok,
  output wire       busy,
  output wire       ready,
  input  wire [1:0] profile,
  input  wire [1:0] nco_select_high_map,
  input  wire [1:0] nco_select_bit_zero_map,
  input  wire [3:0] pin_dir,
  output wire [3:0] gpio_out,
  output wire [3:0] gpio_oe_n
);
  // ***********************************
  // states
  // ***********************************
  localparam [7:0] S_IDLE = 8'h01;
  localparam [7:0] S_PWR  = 8'h02;
  localparam [7:0] S_RST  = 8'h04;
  localparam [7:0] S_SEN  = 8'h08;
  localparam [7:0] S_WR   = 8'h10;
  localparam [7:0] S_WAIT = 8'h20;
  localparam [7:0] S_EST  = 8'h40;
  localparam [7:0] S_DONE = 8'h80;
  localparam [31:0] RST_CYC = `CBS_RST_CYC;
  localparam [31:0] SEN_CYC = `CBS_SEN_CYC;
  localparam [31:0] PWR_C   = PWR_CYC;
  localparam [31:0] EST_C   = EST_CYC;

  // power good and set done cross in through two flops; start and the select inputs are used directly
  reg [1:0] pg_sync_q;
  reg [1:0] dn_sync_q;
  wire      pg = pg_sync_q[1];
  wire      dn = dn_sync_q[1];
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      pg_sync_q <= 2'b00;
      dn_sync_q <= 2'b00;
    end else begin
      pg_sync_q <= {pg_sync_q[0], power_good};
      dn_sync_q <= {dn_sync_q[0], set_done};
    end
  end

  reg [7:0]  state_q;
  reg [31:0] cnt_q;
  reg [2:0]  set_q;
  reg        sen_ok_q;
  reg        ref_en_q;
  reg        conv_rst_q;
  reg        set_req_q;
  reg [2:0]  set_id_q;
  reg        busy_q;
  reg        ready_q;
  reg [31:0] cnt_end;
  wire       cnt_hit = (cnt_q >= cnt_end);

  // ***********************************
  // registered outputs
  // ***********************************
  assign serial_enable_ok = sen_ok_q;
  assign ref_enable       = ref_en_q;
  assign conv_reset       = conv_rst_q;
  assign set_req          = set_req_q;
  assign set_id           = set_id_q;
  assign busy             = busy_q;
  assign ready            = ready_q;

  // ***********************************
  // terminal count of each timed state
  // ***********************************
  // one compare for all waits; every figure is a floor, so round up
  always @* begin
    case (state_q)
      S_PWR:   cnt_end = PWR_C - 32'h0000_0001; // [RQ3]
      S_RST:   cnt_end = RST_CYC - 32'h0000_0001; // [RQ4]
      S_SEN:   cnt_end = SEN_CYC - 32'h0000_0001; // [RQ5]
      S_EST:   cnt_end = EST_C - 32'h0000_0001; // [RQ8]
      default: cnt_end = 32'h0000_0000;
    endcase
  end

  // ***********************************
  // sequence
  // ***********************************
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      state_q    <= S_IDLE;
      cnt_q      <= 32'h0000_0000;
      set_q      <= `CBS_SET_TRIM;
      sen_ok_q   <= 1'b0;
      ref_en_q   <= 1'b0;
      conv_rst_q <= 1'b0;
      set_req_q  <= 1'b0;
      set_id_q   <= `CBS_SET_TRIM;
      busy_q     <= 1'b0;
      ready_q    <= 1'b0;
    end else if (!pg && state_q != S_IDLE) begin
      // supply lost: drop everything, back to idle to wait for a new start [RQ14]
      state_q    <= S_IDLE;
      cnt_q      <= 32'h0000_0000;
      set_q      <= `CBS_SET_TRIM;
      sen_ok_q   <= 1'b0;
      ref_en_q   <= 1'b0;
      conv_rst_q <= 1'b0;
      set_req_q  <= 1'b0;
      set_id_q   <= `CBS_SET_TRIM;
      busy_q     <= 1'b0;
      ready_q    <= 1'b0;
    end else begin
      case (state_q)
        S_IDLE: begin
          if (pg && start) begin
            state_q  <= S_PWR;
            cnt_q    <= 32'h0000_0000;
            busy_q   <= 1'b1;
            ref_en_q <= 1'b1; // [RQ1]
          end
        end
        S_PWR: begin
          // pg is counted from here, a little longer than needed
          cnt_q <= cnt_q + 32'h0000_0001;
          if (cnt_hit) begin // [RQ3]
            state_q    <= S_RST;
            cnt_q      <= 32'h0000_0000;
            conv_rst_q <= 1'b1; // [RQ2]
          end
        end
        S_RST: begin
          cnt_q <= cnt_q + 32'h0000_0001;
          if (cnt_hit) begin // [RQ4]
            state_q    <= S_SEN;
            cnt_q      <= 32'h0000_0000;
            conv_rst_q <= 1'b0; // [RQ2]
          end
        end
        S_SEN: begin
          cnt_q <= cnt_q + 32'h0000_0001;
          if (cnt_hit) begin // [RQ5]
            state_q  <= S_WR;
            cnt_q    <= 32'h0000_0000;
            sen_ok_q <= 1'b1;
            set_q    <= `CBS_SET_TRIM; // [RQ6]
          end
        end
        S_WR: begin
          // four-phase: the writer must drop done before a new request
          if (!dn) begin
            set_req_q <= 1'b1;
            set_id_q  <= set_q;
            state_q   <= S_WAIT;
          end
        end
        S_WAIT: begin
          // hold the request until the writer reports the whole set [RQ14]
          if (dn) begin
            set_req_q <= 1'b0;
            cnt_q     <= 32'h0000_0000;
            if (set_q == `CBS_SET_IL_B) begin
              state_q <= S_EST; // [RQ8]
            end else if (set_q == `CBS_SET_LINK) begin
              state_q <= S_DONE; // [RQ10]
            end else begin
              state_q <= S_WR;
            end
            set_q <= set_q + 3'h1; // [RQ7] [RQ9]
          end
        end
        S_EST: begin
          cnt_q <= cnt_q + 32'h0000_0001;
          if (cnt_hit) begin // [RQ8]
            state_q <= S_WR;
            cnt_q   <= 32'h0000_0000;
          end
        end
        S_DONE: begin
          busy_q  <= 1'b0;
          ready_q <= 1'b1;
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  // ***********************************
  // oscillator select pins
  // ***********************************
  cbs_osc_select cbs_osc_select_inst (
    .sys_clk                 (sys_clk),
    .reset_n                 (reset_n),
    .profile                 (profile),
    .nco_select_high_map     (nco_select_high_map),
    .nco_select_bit_zero_map (nco_select_bit_zero_map),
    .pin_dir                 (pin_dir),
    .gpio_out                (gpio_out),
    .gpio_oe_n               (gpio_oe_n)
  );
endmodule
`default_nettype wire

// ==== design/cbs_defs.vh ====
// timing and step constants for the converter bring-up sequencer
`ifndef CBS_DEFS_VH
`define CBS_DEFS_VH
`define CBS_CLK_MHZ          125
`define CBS_T_PWR_US         1000
`define CBS_T_RST_NS         1000
`define CBS_T_SEN_NS         100
`define CBS_T_EST_US         50000
`define CBS_PWR_CYC          ((`CBS_T_PWR_US * `CBS_CLK_MHZ))
`define CBS_RST_CYC          ((`CBS_T_RST_NS * `CBS_CLK_MHZ + 999) / 1000)
`define CBS_SEN_CYC          ((`CBS_T_SEN_NS * `CBS_CLK_MHZ + 999) / 1000)
`define CBS_EST_CYC          ((`CBS_T_EST_US * `CBS_CLK_MHZ))
`define CBS_SET_TRIM         3'h0
`define CBS_SET_IL_A         3'h1
`define CBS_SET_IL_B         3'h2
`define CBS_SET_NL_A         3'h3
`define CBS_SET_NL_B         3'h4
`define CBS_SET_LINK         3'h5
`define CBS_PROF_NONE        2'h0
`define CBS_PROF_ONE         2'h1
`define CBS_PROF_TWO         2'h2
`define CBS_PROF_THREE       2'h3
`endif

// ==== design/cbs_osc_select.v ====
// oscillator profile select drive for the converter general pins
`timescale 1ns/1ps
`default_nettype none
`include "cbs_defs.vh"
module cbs_osc_select (
  input  wire       sys_clk,
  input  wire       reset_n,
  input  wire [1:0] profile,
  input  wire [1:0] nco_select_high_map,
  input  wire [1:0] nco_select_bit_zero_map,
  input  wire [3:0] pin_dir,
  output reg  [3:0] gpio_out,
  output reg  [3:0] gpio_oe_n
);
  // ***********************************
  // profile code to select bits
  // ***********************************
  reg [1:0] sel_bits;
  always @* begin
    case (profile)
      `CBS_PROF_ONE:   sel_bits = 2'b00; // [RQ11]
      `CBS_PROF_TWO:   sel_bits = 2'b01; // [RQ11]
      `CBS_PROF_THREE: sel_bits = 2'b10; // [RQ11]
      default:         sel_bits = 2'b11; // [RQ11]
    endcase
  end
  // field code to pin index: 00 pin4, 01 pin1, 10 pin3, 11 pin2
  function [1:0] pin_idx;
    input [1:0] code;
    begin
      case (code)
        2'b00:   pin_idx = 2'd3;
        2'b01:   pin_idx = 2'd0;
        2'b10:   pin_idx = 2'd2;
        default: pin_idx = 2'd1;
      endcase
    end
  endfunction
  // ***********************************
  // pin drive
  // ***********************************
  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1) begin : g_pin
      always @(posedge sys_clk) begin
        if (!reset_n) begin
          gpio_out[i]  <= 1'b0;
          gpio_oe_n[i] <= 1'b1;
        end else begin
          // only drive pins the converter treats as inputs [RQ13]
          gpio_oe_n[i] <= pin_dir[i];
          if (pin_idx(nco_select_high_map) == i) begin // [RQ12]
            gpio_out[i] <= sel_bits[1];
          end else if (pin_idx(nco_select_bit_zero_map) == i) begin
            gpio_out[i] <= sel_bits[0]; // [RQ12]
          end else begin
            gpio_out[i] <= 1'b0;
          end
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ==== test/cbs_sequencer_properties.sv ====
// port checks for the bring-up sequencer
`timescale 1ns/1ps
`default_nettype none
module cbs_sequencer_props #(
  parameter PWR_CYC = 20,
  parameter EST_CYC = 50
) (
  input wire logic       sys_clk,
  input wire logic       reset_n,
  input wire logic       power_good,
  input wire logic       ref_enable,
  input wire logic       conv_reset,
  input wire logic       set_req,
  input wire logic [2:0] set_id,
  input wire logic       set_done,
  input wire logic       serial_enable_ok
);
  logic [2:0]  last_q;
  logic [31:0] idle_q;
  logic [31:0] ref_on_q;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // ***
  // helpers; slack of 8 allows the done sync lag
  // ***
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      idle_q   <= 32'h0000_0000;
      ref_on_q <= 32'h0000_0000;
    end else begin
      idle_q   <= set_req ? 32'h0000_0000 : idle_q + 32'h0000_0001;
      ref_on_q <= ref_enable ? ref_on_q + 32'h0000_0001 : 32'h0000_0000;
    end
    if (!reset_n || conv_reset) begin
      last_q <= 3'h7;
    end else if ($fell(set_req)) begin
      last_q <= set_id;
    end
  end
  a_ref_first: assert property ($rose(conv_reset) |-> ref_enable)
    else $error("reset pulse without reference");
  a_pulse_width: assert property ($rose(conv_reset) |-> ##125 $fell(conv_reset))
    else $error("reset pulse width wrong");
  a_power_delay: assert property ($rose(conv_reset) |-> ref_on_q >= PWR_CYC)
    else $error("reset pulse too early");
  a_enable_gap: assert property ($rose(serial_enable_ok) |-> !$past(conv_reset, 13))
    else $error("serial enable too soon");
  a_trim_first: assert property ($rose(serial_enable_ok) |=> set_req && set_id == 3'h0)
    else $error("trim set not first");
  a_set_order: assert property ($rose(set_req) |-> set_id == last_q + 3'h1)
    else $error("set out of order");
  a_est_wait: assert property ($rose(set_req) && set_id == 3'h3 |-> idle_q > EST_CYC - 8)
    else $error("estimation wait short");
  a_hold_req: assert property (set_req && !set_done && power_good |=> set_req && $stable(set_id))
    else $error("request dropped early");
endmodule
bind cbs_sequencer cbs_sequencer_props #(
  .PWR_CYC(PWR_CYC), .EST_CYC(EST_CYC)) cbs_sequencer_props_inst (
  .sys_clk, .reset_n, .power_good, .ref_enable, .conv_reset, .set_req,
  .set_id, .set_done, .serial_enable_ok);
`default_nettype wire

// ==== test/cbs_conv_model.sv ====
// converter stand-in: set writer and select pin decode
`timescale 1ns/1ps
`default_nettype none
module cbs_conv_model #(
  parameter LAT = 4
) (
  input  wire logic       sys_clk,
  input  wire logic       set_req,
  output var  logic       set_done,
  input  wire logic [3:0] gpio_out,
  input  wire logic [3:0] gpio_oe_n,
  input  wire logic [3:0] pin_dir,
  input  wire logic [1:0] hmap,
  input  wire logic [1:0] lmap,
  output wire logic [1:0] osc_prof
);
  logic [7:0] wait_q = 8'h00;
  logic       tog_q = 1'b0;
  initial set_done = 1'b0;
  // undriven pins wander, so no stale level is read
  wire logic [3:0] pin = (gpio_out & ~gpio_oe_n) | ({4{tog_q}} & gpio_oe_n);
  function automatic logic pick(input logic [1:0] m, input logic [3:0] p);
    return p[2'(8'h63 >> {m, 1'b0})];
  endfunction
  // alarm pins feed nothing into the select
  wire logic hi = pick(hmap, pin & ~pin_dir);
  wire logic lo = pick(lmap, pin & ~pin_dir);
  assign osc_prof = {hi, lo} + 2'h1;
  always @(posedge sys_clk) begin
    tog_q <= ~tog_q;
    wait_q <= (set_req && !set_done) ? wait_q + 8'h01 : 8'h00;
    set_done <= set_req && (set_done || wait_q == LAT);
  end
endmodule
`default_nettype wire

// ==== test/cbs_sequencer_tb.sv ====
// self-checking bench for the bring-up sequencer
`timescale 1ns/1ps
`default_nettype none
module cbs_sequencer_tb;
  logic       sys_clk = 0, reset_n = 0, power_good = 0, start = 0;
  logic       ref_enable, conv_reset, set_req, set_done, busy, ready;
  logic       serial_enable_ok;
  logic [2:0] set_id;
  logic [1:0] profile = 0, hmap = 0, lmap = 0, osc_prof;
  logic [3:0] pin_dir = 0, gpio_out, gpio_oe_n;
  int         errors = 0, compares = 0;
  always #4 sys_clk = ~sys_clk;
  cbs_sequencer #(.PWR_CYC(20), .EST_CYC(50)) cbs_sequencer_inst (
    .sys_clk, .reset_n, .power_good, .start, .ref_enable, .conv_reset,
    .set_req, .set_id, .set_done, .serial_enable_ok, .busy, .ready,
    .profile, .nco_select_high_map(hmap), .nco_select_bit_zero_map(lmap),
    .pin_dir, .gpio_out, .gpio_oe_n);
  cbs_conv_model cbs_conv_model_inst (.sys_clk, .set_req, .set_done,
    .gpio_out, .gpio_oe_n, .pin_dir, .hmap, .lmap, .osc_prof);
  task chk(input string nm, input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task test_done;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic t_bringup;
    int n, rr = 0, rf = 0, so = 0, tq[$];
    logic [2:0] ids[$];
    logic pq = 0;
    power_good = 1;
    start = 1;
    for (n = 1; n < 3000 && !ready; n++) begin
      @(negedge sys_clk);
      if (busy) start = 0;
      if (conv_reset && !rr) rr = n;
      if (!conv_reset && rr && !rf) rf = n;
      if (serial_enable_ok && !so) so = n;
      if (set_req && !pq) begin
        ids.push_back(set_id);
        tq.push_back(n);
      end
      pq = set_req;
    end
    chk("reset delay", rr > 20, 1);
    chk("reset width", rf - rr, 125);
    chk("enable gap", so - rf, 13);
    chk("set count", ids.size(), 6);
    for (n = 0; n < 6; n++) chk("set id", ids[n], n);
    chk("est wait", tq[3] - tq[2] > 50, 1);
    chk("ready", {ready, ref_enable}, 3);
    $display("bring-up test done");
  endtask
  task automatic t_power_loss;
    power_good = 1;
    start = 1;
    repeat (8) @(negedge sys_clk);
    chk("ref on", {ref_enable, conv_reset}, 2);
    power_good = 0;
    start = 0;
    repeat (5) @(negedge sys_clk);
    chk("abort", {ref_enable, busy}, 0);
    t_bringup;
    $display("power loss test done");
  endtask
  task automatic t_osc;
    int p;
    for (p = 0; p < 16; p++) begin
      profile = 2'(p >> 2);
      hmap = 2'(p);
      lmap = 2'(p + 1);
      repeat (3) @(negedge sys_clk);
      chk("profile", osc_prof, p >> 2);
    end
    pin_dir = 4'h5;
    repeat (3) @(negedge sys_clk);
    chk("pin drive", gpio_oe_n, 4'h5);
    chk("profile alarm", osc_prof, 3);
    pin_dir = 4'h0;
    $display("oscillator select test done");
  endtask
  initial begin
    repeat (20) @(negedge sys_clk);
    reset_n = 1;
    t_osc;
    t_power_loss;
    test_done;
  end
  initial begin
    #50us;
    errors++;
    test_done;
  end
endmodule
`default_nettype wire
